// >>> design/dhi_fifo.sv
// small valid/ready fifo for received bytes
`timescale 1ns/1ps
module dhi_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule : dhi_fifo

// >>> design/dhi_host_port.sv
// host command/data port: parallel, spi and i2c front ends
`timescale 1ns/1ps
// Notes on behaviour
// - eight data, five control lines; mode fixed by three strap pins.
// - 6800 read/write low writes, high reads; dc low status, high data.
// - parallel and 4-wire modes: dc low is command, high is data.
// - 6800 captures on strobe falling edge while chip select low.
// - first parallel display read is a dummy; real data from second.
// - 8080 read completes on read strobe rising edge with select low.
// - 8080 write latches on write strobe rising edge with select low.
// - 4-wire spi shifts serial_in msb first on rising serial clock.
// - 4-wire spi samples dc on eighth clock; host holds it stable.
// - 4-wire byte delivered on the clock completing the eighth bit.
// - serial modes are write only, no read path.
// - 3-wire spi word is flag bit then data bits seven to zero.
// - 3-wire flag one routes to display ram, zero to command.
// - i2c answers only address 0111100 or 0111101 per addr_select_bit.
// - i2c matches address first, ignores transfers for other slaves.
// - i2c read/write bit one reads, zero writes.
// - data and acknowledges share the i2c line; ack via data out pin.
// - control byte holds continuation and dc flags then six zeros.
// - continuation zero makes all following bytes data only.
// - column pointer advances by one after each display data write.
// - reset pin low clears the serial shift register.
module dhi_host_port
    import dhi_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // straps and control pins
    input wire logic [2:0] interface_select_straps,
    input wire logic chip_select_n,
    input wire logic cmd_data_select,
    input wire logic read_write_n,
    input wire logic parallel_strobe,
    // parallel data pins
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // serial pins
    input wire logic serial_clock,
    input wire logic serial_in,
    output logic i2c_data_out_pin,
    output logic i2c_data_oe,
    // core side
    output logic byte_valid,
    input wire logic byte_ready,
    output logic [7:0] byte_data,
    output logic byte_is_data,
    input wire logic [7:0] status_in,
    input wire logic [7:0] ram_rd_data,
    output logic [dhi_pkg::DHI_COL_W-1:0] column_ptr,
    output logic port_stall
);
    import dhi_pkg::*;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // order: cs_n, dc, rw, strobe, sclk, serial_in
    logic [5:0] sy1_q;
    logic [5:0] sy2_q;
    logic [5:0] sy3_q;
    logic [7:0] din_q1;
    logic [7:0] din_q2;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sy1_q <= 6'h3F;
            sy2_q <= 6'h3F;
            sy3_q <= 6'h3F;
            din_q1 <= 8'h00;
            din_q2 <= 8'h00;
        end else begin
            sy1_q <= {chip_select_n, cmd_data_select, read_write_n, parallel_strobe,
                      serial_clock, serial_in};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            din_q1 <= data_in;
            din_q2 <= din_q1;
        end
    end
    logic cs_n_s, dc_s, rw_s, stb_s, sclk_s, serial_in_s, sclk_p, stb_p, sda_p;
    assign {cs_n_s, dc_s, rw_s, stb_s, sclk_s, serial_in_s} = sy2_q;
    assign sclk_p = sy3_q[1];
    assign stb_p = sy3_q[2];
    assign sda_p = sy3_q[0];
    logic [2:0] mode_q;
    // straps re-sampled on every clock after reset release, not held fixed
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= 3'h0;
        end else begin
            mode_q <= interface_select_straps;
        end
    end
    wire is_6800 = mode_q == DHI_MODE_6800;
    wire is_8080 = mode_q == DHI_MODE_8080;
    wire is_spi4 = mode_q == DHI_MODE_SPI4;
    wire is_spi3 = mode_q == DHI_MODE_SPI3;
    wire is_i2c = mode_q == DHI_MODE_I2C;
    wire sclk_rise = sclk_s && !sclk_p;
    wire sclk_fall = !sclk_s && sclk_p;
    // ----------------------------------------
    // parallel strobe decode
    // ----------------------------------------
    // 6800: E falls; 8080: rd#/wr# rise (rd# on strobe, wr# on rw pin)
    wire e_fall = is_6800 && !stb_s && stb_p && !cs_n_s;
    wire rw_rise = rw_s && !sy3_q[3];
    wire par_wr = (e_fall && !rw_s) || (is_8080 && !cs_n_s && rw_rise);
    wire par_rd = (e_fall && rw_s) || (is_8080 && !cs_n_s && stb_s && !stb_p);
    // ----------------------------------------
    // serial shift (spi and i2c)
    // ----------------------------------------
    typedef enum logic [3:0] {
        DHI_I2C_IDLE_S = 4'h1,
        DHI_I2C_ADDR_S = 4'h2,
        DHI_I2C_CTRL_S = 4'h4,
        DHI_I2C_DATA_S = 4'h8
    } dhi_i2c_t;
    dhi_i2c_t i2c_q;
    logic [8:0] sh_q;
    logic [3:0] bit_q;
    logic i2c_dc_q, i2c_cont_q, ack_q;
    wire i2c_start = is_i2c && sclk_s && sclk_p && sda_p && !serial_in_s;
    wire i2c_stop = is_i2c && sclk_s && sclk_p && !sda_p && serial_in_s;
    wire spi_on = (is_spi4 || is_spi3) && !cs_n_s;
    wire [3:0] spi_len = is_spi3 ? DHI_SPI3_BITS : DHI_SPI4_BITS;
    wire spi_done = spi_on && sclk_rise && (bit_q == spi_len - 4'h1);
    wire i2c_byte = is_i2c && sclk_rise && bit_q == DHI_I2C_ACK_BIT - 4'h1;
    wire [8:0] sh_next = {sh_q[7:0], serial_in_s};
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_q <= 9'h000;
            bit_q <= 4'h0;
        end else if ((is_spi4 || is_spi3) && cs_n_s) begin
            bit_q <= 4'h0;
        end else if (i2c_start || i2c_stop) begin
            bit_q <= 4'h0;
        end else if (spi_on && sclk_rise) begin
            sh_q <= sh_next;
            bit_q <= spi_done ? 4'h0 : bit_q + 4'h1;
        end else if (is_i2c && sclk_rise && i2c_q != DHI_I2C_IDLE_S) begin
            if (bit_q < DHI_I2C_ACK_BIT) begin
                sh_q <= sh_next;
            end
            bit_q <= (bit_q == DHI_I2C_ACK_BIT) ? 4'h0 : bit_q + 4'h1;
        end
    end
    // ----------------------------------------
    // i2c protocol state
    // ----------------------------------------
    wire [6:0] my_addr = {DHI_I2C_ADDR_HI, dc_s};
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            i2c_q <= DHI_I2C_IDLE_S;
            i2c_dc_q <= 1'b0;
            i2c_cont_q <= 1'b1;
            ack_q <= 1'b0;
        end else if (!is_i2c || i2c_stop) begin
            i2c_q <= DHI_I2C_IDLE_S;
            ack_q <= 1'b0;
        end else if (i2c_start) begin
            i2c_q <= DHI_I2C_ADDR_S;
            i2c_cont_q <= 1'b1;
            ack_q <= 1'b0;
        end else begin
            if (sclk_fall && bit_q == DHI_I2C_ACK_BIT) begin
                ack_q <= 1'b1;
            end else if (sclk_fall) begin
                ack_q <= 1'b0;
            end
            if (i2c_byte) begin
                unique case (i2c_q)
                    DHI_I2C_ADDR_S: begin
                        // read mode (bit 1) has no path here; treated as not ours
                        if (sh_next[7:1] == my_addr && !sh_next[0]) begin
                            i2c_q <= DHI_I2C_CTRL_S;
                        end else begin
                            i2c_q <= DHI_I2C_IDLE_S;
                        end
                    end
                    DHI_I2C_CTRL_S: begin
                        i2c_dc_q <= sh_next[DHI_CTRL_DC_BIT];
                        i2c_cont_q <= sh_next[DHI_CTRL_CONT_BIT];
                        i2c_q <= DHI_I2C_DATA_S;
                    end
                    DHI_I2C_DATA_S: begin
                        if (i2c_cont_q) begin
                            i2c_q <= DHI_I2C_CTRL_S;
                        end else begin
                            i2c_q <= DHI_I2C_DATA_S;
                        end
                    end
                    DHI_I2C_IDLE_S: begin
                        i2c_q <= DHI_I2C_IDLE_S;
                    end
                endcase
            end
        end
    end
    // ack held low through the ninth clock; pin may be left open by host
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            i2c_data_out_pin <= 1'b0;
            i2c_data_oe <= 1'b0;
        end else begin
            i2c_data_out_pin <= 1'b0;
            i2c_data_oe <= ack_q && i2c_q != DHI_I2C_IDLE_S;
        end
    end
    // ----------------------------------------
    // byte delivery into fifo
    // ----------------------------------------
    logic push_v;
    logic [8:0] push_d;
    logic fifo_in_ready;
    always_comb begin
        push_v = 1'b0;
        push_d = 9'h000;
        if (par_wr) begin
            push_v = 1'b1;
            push_d = {dc_s, din_q2};
        end else if (spi_done && is_spi4) begin
            push_v = 1'b1;
            push_d = {dc_s, sh_next[7:0]};
        end else if (spi_done && is_spi3) begin
            push_v = 1'b1;
            push_d = sh_next;
        end else if (i2c_byte && i2c_q == DHI_I2C_DATA_S) begin
            push_v = 1'b1;
            push_d = {i2c_dc_q, sh_next[7:0]};
        end
    end
    logic fifo_out_valid;
    logic [8:0] fifo_out_data;
    dhi_fifo #(.WIDTH(DHI_FIFO_W), .DEPTH(DHI_FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(push_v),
        .in_ready(fifo_in_ready),
        .in_data(push_d),
        .out_valid(fifo_out_valid),
        .out_ready(byte_ready && !byte_valid),
        .out_data(fifo_out_data)
    );
    // registered output stage; pops one byte per handshake
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
            byte_is_data <= 1'b0;
            port_stall <= 1'b0;
            column_ptr <= '0;
        end else begin
            byte_valid <= fifo_out_valid && byte_ready && !byte_valid;
            if (fifo_out_valid && byte_ready && !byte_valid) begin
                byte_data <= fifo_out_data[7:0];
                byte_is_data <= fifo_out_data[8];
                if (fifo_out_data[8]) begin
                    column_ptr <= column_ptr + 8'h01;
                end
            end
            port_stall <= !fifo_in_ready;
        end
    end
    // ----------------------------------------
    // parallel read path (serial modes never drive)
    // ----------------------------------------
    logic [7:0] rd_pipe_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_pipe_q <= 8'h00;
            data_out <= DHI_STATUS_IDLE;
            data_oe <= 1'b0;
        end else begin
            // reading drives bus while strobe active; serial modes never drive
            data_oe <= !cs_n_s && ((is_6800 && rw_s && stb_s) || (is_8080 && !stb_s));
            if (par_rd && dc_s) begin
                data_out <= rd_pipe_q;
                rd_pipe_q <= ram_rd_data;
            end else if (par_rd) begin
                data_out <= status_in;
            end
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    serial_no_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !(is_6800 || is_8080) |=> !data_oe) else $error("data bus driven in serial mode");
    cs_ignores_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cs_n_s |-> !par_wr && !par_rd && !spi_on) else $error("strobe taken while deselected");
    spi4_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        is_spi4 |-> bit_q < DHI_SPI4_BITS) else $error("spi4 bit count overran");
    spi_push_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        spi_done |-> push_v) else $error("spi byte not delivered");
    spi3_route_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        spi_done && is_spi3 |-> push_d[8] == sh_q[7]) else $error("3-wire flag misrouted");
    par_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        par_wr |-> push_d == {dc_s, din_q2}) else $error("parallel byte mismatch");
    col_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        byte_valid && byte_is_data |-> column_ptr == $past(column_ptr) + 8'h01)
        else $error("column pointer did not step");
    addr_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        i2c_q == DHI_I2C_ADDR_S && i2c_byte && sh_next[7:1] != my_addr
        |=> i2c_q == DHI_I2C_IDLE_S) else $error("foreign i2c address accepted");
    cmd_write_c: cover property (@(posedge sys_clk) disable iff (!rst_b) par_wr && !dc_s);
    spi3_data_c: cover property (@(posedge sys_clk) disable iff (!rst_b) spi_done && is_spi3);
    i2c_data_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        i2c_byte && i2c_q == DHI_I2C_DATA_S);
    stall_c: cover property (@(posedge sys_clk) disable iff (!rst_b) port_stall);
endmodule : dhi_host_port

// >>> design/dhi_pkg.sv
// package of constants for the display host interface
package dhi_pkg;
    // ----------------------------------------
    // interface select strap codes
    // ----------------------------------------
    localparam logic [2:0] DHI_MODE_I2C = 3'h0;
    localparam logic [2:0] DHI_MODE_SPI3 = 3'h1;
    localparam logic [2:0] DHI_MODE_SPI4 = 3'h2;
    localparam logic [2:0] DHI_MODE_8080 = 3'h6;
    localparam logic [2:0] DHI_MODE_6800 = 3'h4;
    // ----------------------------------------
    // i2c addressing
    // ----------------------------------------
    localparam logic [5:0] DHI_I2C_ADDR_HI = 6'h1E;
    localparam int DHI_CTRL_CONT_BIT = 7;
    localparam int DHI_CTRL_DC_BIT = 6;
    // ----------------------------------------
    // widths, counts, fifo
    // ----------------------------------------
    localparam int DHI_DATA_W = 8;
    localparam int DHI_FIFO_W = 9;
    localparam int DHI_FIFO_DEPTH = 8;
    localparam int DHI_COL_W = 8;
    localparam logic [3:0] DHI_SPI4_BITS = 4'h8;
    localparam logic [3:0] DHI_SPI3_BITS = 4'h9;
    localparam logic [3:0] DHI_I2C_ACK_BIT = 4'h8;
    localparam logic [3:0] DHI_I2C_LAST_BIT = 4'h9;
    localparam logic [7:0] DHI_STATUS_IDLE = 8'h00;
endpackage : dhi_pkg

// >>> testbench/dhi_host_model.sv
// microcontroller model driving the host port pins in every bus mode
`timescale 1ns/1ps
module dhi_host_model
    import dhi_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // pins toward the port
    output logic chip_select_n,
    output logic cmd_data_select,
    output logic read_write_n,
    output logic parallel_strobe,
    output logic [7:0] data_in,
    output logic serial_clock,
    output wire logic serial_in,
    // pins from the port
    input wire logic [7:0] data_out,
    input wire logic i2c_data_oe
);
    logic sda_q = 1'b1;
    logic [2:0] mode_q = DHI_MODE_SPI4;
    // pulled-up shared line: low whenever the port acknowledges
    assign serial_in = sda_q & ~i2c_data_oe;
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hold
    task automatic idle(input logic [2:0] m);
        mode_q = m;
        chip_select_n <= 1'b1;
        cmd_data_select <= 1'b0;
        data_in <= 8'h00;
        read_write_n <= (m == DHI_MODE_8080);
        parallel_strobe <= (m == DHI_MODE_8080);
        serial_clock <= (m == DHI_MODE_I2C);
        sda_q <= 1'b1;
    endtask : idle
    task automatic spi(input logic [8:0] w, input int n, input logic dc, input logic sel);
        chip_select_n <= ~sel;
        cmd_data_select <= dc;
        hold(4);
        for (int i = n - 1; i >= 0; i--) begin
            sda_q <= w[i];
            hold(4);
            serial_clock <= 1'b1;
            hold(4);
            serial_clock <= 1'b0;
        end
        // released line shows the inverse so a stale bit never looks valid
        sda_q <= ~w[0];
        hold(4);
        chip_select_n <= 1'b1;
        hold(4);
    endtask : spi
    task automatic par_wr(input logic dc, input logic [7:0] d, input logic sel);
        chip_select_n <= ~sel;
        cmd_data_select <= dc;
        data_in <= d;
        if (mode_q == DHI_MODE_6800) begin
            read_write_n <= 1'b0;
            hold(4);
            parallel_strobe <= 1'b1;
            hold(4);
            parallel_strobe <= 1'b0;
        end else begin
            hold(4);
            read_write_n <= 1'b0;
            hold(4);
            read_write_n <= 1'b1;
        end
        hold(4);
        chip_select_n <= 1'b1;
        data_in <= ~d;
        hold(4);
    endtask : par_wr
    task automatic par_rd(input logic dc, output logic [7:0] d);
        chip_select_n <= 1'b0;
        cmd_data_select <= dc;
        if (mode_q == DHI_MODE_6800) begin
            read_write_n <= 1'b1;
            hold(4);
            parallel_strobe <= 1'b1;
            hold(4);
            parallel_strobe <= 1'b0;
        end else begin
            hold(4);
            parallel_strobe <= 1'b0;
            hold(4);
            parallel_strobe <= 1'b1;
        end
        hold(8);
        d = data_out;
        chip_select_n <= 1'b1;
        hold(4);
    endtask : par_rd
    task automatic i2c_start(input logic sa);
        cmd_data_select <= sa;
        sda_q <= 1'b0;
        hold(4);
        serial_clock <= 1'b0;
        hold(4);
    endtask : i2c_start
    task automatic i2c_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_q <= b[i];
            hold(2);
            serial_clock <= 1'b1;
            hold(4);
            serial_clock <= 1'b0;
            hold(2);
        end
        sda_q <= 1'b1;
        hold(2);
        serial_clock <= 1'b1;
        hold(2);
        ack = i2c_data_oe;
        hold(2);
        serial_clock <= 1'b0;
        // let the acknowledge release settle before the next bit
        hold(4);
    endtask : i2c_byte
    task automatic i2c_stop();
        sda_q <= 1'b0;
        hold(4);
        serial_clock <= 1'b1;
        hold(4);
        sda_q <= 1'b1;
        hold(4);
    endtask : i2c_stop
endmodule : dhi_host_model

// >>> testbench/display_host_interface_tb.sv
// self-checking bench for the display host port
`timescale 1ns/1ps
module display_host_interface_tb;
    import dhi_pkg::*;
    // ----------------------------------------
    // bench signals
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] interface_select_straps = DHI_MODE_SPI4;
    logic byte_ready = 1'b1;
    logic [7:0] status_in = 8'h5C;
    logic [7:0] ram_rd_data = 8'h96;
    wire logic chip_select_n, cmd_data_select, read_write_n, parallel_strobe;
    wire logic serial_clock, serial_in, data_oe, i2c_data_out_pin, i2c_data_oe;
    wire logic byte_valid, byte_is_data, port_stall;
    wire logic [7:0] data_in, data_out, byte_data, column_ptr;
    int fails = 0;
    int comparisons = 0;
    logic [8:0] exp_q[$];
    logic [8:0] got_q[$];
    logic [7:0] cp_exp = 8'h00;
    logic [7:0] rd;
    logic ack;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (byte_valid === 1'b1) got_q.push_back({byte_is_data, byte_data});
    dhi_host_port DUT (.sys_clk, .rst_b, .interface_select_straps, .chip_select_n,
        .cmd_data_select, .read_write_n, .parallel_strobe, .data_in, .data_out, .data_oe,
        .serial_clock, .serial_in, .i2c_data_out_pin, .i2c_data_oe, .byte_valid, .byte_ready,
        .byte_data, .byte_is_data, .status_in, .ram_rd_data, .column_ptr, .port_stall);
    dhi_host_model mcu (.sys_clk, .chip_select_n, .cmd_data_select, .read_write_n,
        .parallel_strobe, .data_in, .serial_clock, .serial_in, .data_out, .i2c_data_oe);
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic put(input logic isd, input logic [7:0] d);
        exp_q.push_back({isd, d});
        if (isd) cp_exp++;
    endtask : put
    task automatic start(input logic [2:0] m);
        mcu.hold(1);
        rst_b <= 1'b0;
        interface_select_straps <= m;
        mcu.idle(m);
        mcu.hold(16);
        chk("column reset", 16'(column_ptr), 16'h0000);
        rst_b <= 1'b1;
        mcu.hold(8);
        cp_exp = 8'h00;
        got_q.delete();
        exp_q.delete();
    endtask : start
    task automatic check_rx();
        mcu.hold(12);
        for (int i = 0; i < 400 && got_q.size() < exp_q.size(); i++) mcu.hold(1);
        if (got_q.size() < exp_q.size()) begin
            $display("[FAIL] byte wait expected %0d seen %0d", exp_q.size(), got_q.size());
            fails++;
            test_done();
        end
        mcu.hold(12);
        chk("byte count", 16'(got_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) chk("byte", 16'(got_q[i]), 16'(exp_q[i]));
        chk("column", 16'(column_ptr), 16'(cp_exp));
        got_q.delete();
        exp_q.delete();
    endtask : check_rx
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        test_done();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        start(DHI_MODE_SPI4);
        mcu.spi(9'h0A5, 8, 1'b0, 1'b1);
        put(1'b0, 8'hA5);
        mcu.spi(9'h03C, 8, 1'b1, 1'b1);
        put(1'b1, 8'h3C);
        // deselected clocks, then a partial byte cut short by deselect
        mcu.spi(9'h0FF, 8, 1'b1, 1'b0);
        mcu.spi(9'h007, 3, 1'b1, 1'b1);
        mcu.spi(9'h081, 8, 1'b1, 1'b1);
        put(1'b1, 8'h81);
        check_rx();
        start(DHI_MODE_SPI3);
        mcu.spi(9'h15A, 9, 1'b0, 1'b1);
        put(1'b1, 8'h5A);
        mcu.spi(9'h0C3, 9, 1'b1, 1'b1);
        put(1'b0, 8'hC3);
        check_rx();
        start(DHI_MODE_I2C);
        for (int s = 0; s < 2; s++) begin
            mcu.i2c_start(s[0]);
            mcu.i2c_byte({DHI_I2C_ADDR_HI, s[0], 1'b0}, ack);
            chk("address ack", 16'(ack), 16'h0001);
            mcu.i2c_byte(8'h40, ack);
            chk("control ack", 16'(ack), 16'h0001);
            mcu.i2c_byte(8'h00, ack);
            put(1'b1, 8'h00);
            mcu.i2c_byte(8'h70 + 8'(s), ack);
            put(1'b1, 8'h70 + 8'(s));
            mcu.i2c_stop();
        end
        mcu.i2c_start(1'b0);
        mcu.i2c_byte({DHI_I2C_ADDR_HI, 1'b0, 1'b0}, ack);
        mcu.i2c_byte(8'h00, ack);
        mcu.i2c_byte(8'hAF, ack);
        put(1'b0, 8'hAF);
        mcu.i2c_stop();
        mcu.i2c_start(1'b0);
        mcu.i2c_byte({DHI_I2C_ADDR_HI, 1'b1, 1'b0}, ack);
        chk("foreign ack", 16'(ack), 16'h0000);
        mcu.i2c_byte(8'h40, ack);
        mcu.i2c_byte(8'h11, ack);
        mcu.i2c_stop();
        mcu.i2c_start(1'b0);
        mcu.i2c_byte({DHI_I2C_ADDR_HI, 1'b0, 1'b1}, ack);
        chk("read ack", 16'(ack), 16'h0000);
        mcu.i2c_stop();
        check_rx();
        for (int k = 0; k < 2; k++) begin
            start(k == 0 ? DHI_MODE_6800 : DHI_MODE_8080);
            mcu.par_wr(1'b0, 8'h21, 1'b1);
            put(1'b0, 8'h21);
            mcu.par_wr(1'b1, 8'h22, 1'b1);
            put(1'b1, 8'h22);
            mcu.par_wr(1'b1, 8'h99, 1'b0);
            check_rx();
            mcu.par_rd(1'b0, rd);
            chk("status read", 16'(rd), 16'(status_in));
            mcu.par_rd(1'b1, rd);
            mcu.par_rd(1'b1, rd);
            chk("data read", 16'(rd), 16'(ram_rd_data));
        end
        start(DHI_MODE_SPI4);
        byte_ready <= 1'b0;
        for (int i = 0; i < 10; i++) mcu.spi(9'(i), 8, 1'b1, 1'b1);
        chk("stall", 16'(port_stall), 16'h0001);
        byte_ready <= 1'b1;
        mcu.hold(80);
        chk("stall clear", 16'(port_stall), 16'h0000);
        for (int i = 0; i < 8; i++) chk("drained", 16'(got_q[i]), 16'(9'h100 + 9'(i)));
        test_done();
    end
endmodule : display_host_interface_tb
